// File: audio_routing_map.svh
`ifndef AUDIO_ROUTING_MAP_SVH
`define AUDIO_ROUTING_MAP_SVH

// ----------------------------------------------------------------------------
// Device register subaddresses and reset values
// ----------------------------------------------------------------------------
`define SUB_DAC_SOURCE_SELECT     8'h13
`define SUB_ANALOG_OUTPUT_SELECT  8'h14
`define SUB_DIGITAL_AUDIO_CONFIG  8'h15
`define RST_DAC_SOURCE_SELECT     8'h00
`define RST_ANALOG_OUTPUT_SELECT  8'h00
`define RST_DIGITAL_AUDIO_CONFIG  8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DAC_SRC_LO_POS            0
`define DAC_SRC_HI_POS            1
`define DAC_GAIN_LO_POS           3
`define DAC_GAIN_HI_POS           7
`define DAC_USED_MASK             8'h8b
`define ANALOG_SRC_LO_POS         0
`define ANALOG_SRC_HI_POS         1
`define MATRIX_MODE_0_POS         4
`define MATRIX_MODE_2_POS         6
`define ANALOG_USED_MASK          8'h73
`define SERIAL_AUDIO_ENABLE_POS   0
`define SERIAL_FORMAT_SELECT_POS  1
`define MCLK_OUT_ENABLE_POS       2
`define MCLK_FREQ_LO_POS          3
`define MCLK_FREQ_HI_POS          4
`define DIGITAL_USED_MASK         8'h1f

// ----------------------------------------------------------------------------
// Link framing and controller registers
// ----------------------------------------------------------------------------
`define LINK_WORD_BITS            16
`define LINK_HALF_DEFAULT         2
`define CTRL_CMD_OFFSET           12'h000
`define CTRL_STATUS_OFFSET        12'h004
`define CTRL_BUSY_POS             0
`define CTRL_DONE_POS             1

`endif

// File: audio_routing_pkg.sv
package audio_routing_pkg;

  typedef enum logic [1:0] {
    ASRC_DAC      = 2'b00,
    ASRC_RESERVED = 2'b01,
    ASRC_EXTERNAL = 2'b10,
    ASRC_MONO     = 2'b11
  } analog_src_e;

  typedef enum logic [2:0] {
    MTX_STRAIGHT = 3'b000,
    MTX_LEFT     = 3'b001,
    MTX_RIGHT    = 3'b010,
    MTX_SWAP     = 3'b011,
    MTX_AVERAGE  = 3'b100
  } matrix_mode_e;

  typedef enum logic {
    CTRL_IDLE,
    CTRL_SEND
  } ctrl_state_e;

endpackage : audio_routing_pkg

// File: audio_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface audio_link_if;
  logic link_clk;
  logic frame;
  logic data;

  modport ctrl (output link_clk, output frame, output data);
  modport dev  (input link_clk, input frame, input data);
endinterface : audio_link_if

`default_nettype wire

// File: audio_routing_dev.sv
// Implementation choice: the serial link interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "audio_routing_map.svh"

module audio_routing_dev (
  input  wire logic       rst_b_i,
  audio_link_if.dev       link,
  input  wire logic       automute_fallback_select_i,
  output logic [1:0]      dac_src_o,
  output logic [1:0]      dac_gain_o,
  output logic [3:0]      dac_gain_db_o,
  output logic [1:0]      analog_src_o,
  output logic [2:0]      matrix_mode_o,
  output logic            dac_mute_o,
  output logic            automute_fallback_o,
  output logic [1:0]      mclk_freq_o,
  output logic [9:0]      mclk_ratio_o,
  output logic            master_clock_pin_oe_o,
  output logic            serial_format_o,
  output logic            serial_audio_oe_o
);

  // --------------------------------------------------------------------------
  // Field decoding
  // --------------------------------------------------------------------------
  function automatic logic [1:0] analog_src_fn(input logic [7:0] reg_v);
    logic [1:0] src;
    src = {reg_v[`ANALOG_SRC_HI_POS], reg_v[`ANALOG_SRC_LO_POS]};
    if (src == audio_routing_pkg::ASRC_RESERVED) begin
      src = audio_routing_pkg::ASRC_DAC;
    end
    return src;
  endfunction : analog_src_fn

  function automatic logic [2:0] matrix_fn(input logic [7:0] reg_v);
    logic [2:0] mode;
    logic [1:0] src;
    mode = reg_v[`MATRIX_MODE_2_POS:`MATRIX_MODE_0_POS];
    src  = analog_src_fn(reg_v);
    if (mode > audio_routing_pkg::MTX_AVERAGE) begin
      mode = audio_routing_pkg::MTX_STRAIGHT;
    end
    if (mode == audio_routing_pkg::MTX_AVERAGE && src != audio_routing_pkg::ASRC_DAC) begin
      mode = audio_routing_pkg::MTX_STRAIGHT;
    end
    return mode;
  endfunction : matrix_fn

  function automatic logic [9:0] ratio_fn(input logic [1:0] code);
    logic [9:0] r;
    r = 10'h100;
    unique case (code)
      2'b00: r = 10'h100;
      2'b01: r = 10'h180;
      2'b10: r = 10'h200;
      2'b11: r = 10'h300;
    endcase
    return r;
  endfunction : ratio_fn

  function automatic logic [3:0] gain_db_fn(input logic [1:0] code);
    logic [3:0] g;
    g = 4'h0;
    unique case (code)
      2'b00: g = 4'h0;
      2'b01: g = 4'h3;
      2'b10: g = 4'h6;
      2'b11: g = 4'h9;
    endcase
    return g;
  endfunction : gain_db_fn

  // --------------------------------------------------------------------------
  // Link receiver
  // --------------------------------------------------------------------------
  logic [14:0] shift_q;
  logic [3:0]  bit_cnt_q;
  logic        commit;
  logic [15:0] word;

  assign word   = {shift_q, link.data};
  assign commit = link.frame && (bit_cnt_q == 4'hf);

  always_ff @(posedge link.link_clk) begin
    if (!rst_b_i) begin
      shift_q   <= 15'h0000;
      bit_cnt_q <= 4'h0;
    end else if (link.frame) begin
      shift_q   <= word[14:0];
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else begin
      bit_cnt_q <= 4'h0;
    end
  end

  // --------------------------------------------------------------------------
  // Register bank
  // --------------------------------------------------------------------------
  logic [7:0] dac_select_q;
  logic [7:0] analog_select_q;
  logic [7:0] digital_config_q;

  always_ff @(posedge link.link_clk) begin
    if (!rst_b_i) begin
      dac_select_q <= `RST_DAC_SOURCE_SELECT;
    end else if (commit && word[15:8] == `SUB_DAC_SOURCE_SELECT) begin
      dac_select_q <= word[7:0];
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!rst_b_i) begin
      analog_select_q <= `RST_ANALOG_OUTPUT_SELECT;
    end else if (commit && word[15:8] == `SUB_ANALOG_OUTPUT_SELECT) begin
      analog_select_q <= word[7:0];
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!rst_b_i) begin
      digital_config_q <= `RST_DIGITAL_AUDIO_CONFIG;
    end else if (commit && word[15:8] == `SUB_DIGITAL_AUDIO_CONFIG) begin
      digital_config_q <= word[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Fallback select synchroniser
  // --------------------------------------------------------------------------
  logic fallback_meta_q;
  logic fallback_sync_q;

  always_ff @(posedge link.link_clk) begin
    if (!rst_b_i) begin
      fallback_meta_q <= 1'b0;
      fallback_sync_q <= 1'b0;
    end else begin
      fallback_meta_q <= automute_fallback_select_i;
      fallback_sync_q <= fallback_meta_q;
    end
  end

  // --------------------------------------------------------------------------
  // Routing outputs
  // --------------------------------------------------------------------------
  logic [1:0] asrc;

  assign asrc = analog_src_fn(analog_select_q);

  always_ff @(posedge link.link_clk) begin
    if (!rst_b_i) begin
      dac_src_o     <= 2'b00;
      dac_gain_o    <= 2'b00;
      dac_gain_db_o <= 4'h0;
    end else begin
      dac_src_o     <= {dac_select_q[`DAC_SRC_HI_POS], dac_select_q[`DAC_SRC_LO_POS]};
      dac_gain_o    <= {dac_select_q[`DAC_GAIN_HI_POS], dac_select_q[`DAC_GAIN_LO_POS]};
      dac_gain_db_o <= gain_db_fn({dac_select_q[`DAC_GAIN_HI_POS], dac_select_q[`DAC_GAIN_LO_POS]});
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!rst_b_i) begin
      analog_src_o        <= 2'b00;
      matrix_mode_o       <= 3'b000;
      dac_mute_o          <= 1'b0;
      automute_fallback_o <= 1'b0;
    end else begin
      analog_src_o        <= asrc;
      matrix_mode_o       <= matrix_fn(analog_select_q);
      dac_mute_o          <= (asrc != audio_routing_pkg::ASRC_DAC);
      automute_fallback_o <= fallback_sync_q && (asrc == audio_routing_pkg::ASRC_DAC);
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!rst_b_i) begin
      mclk_freq_o           <= 2'b00;
      mclk_ratio_o          <= 10'h100;
      master_clock_pin_oe_o <= 1'b0;
      serial_format_o       <= 1'b0;
      serial_audio_oe_o     <= 1'b0;
    end else begin
      mclk_freq_o           <= digital_config_q[`MCLK_FREQ_HI_POS:`MCLK_FREQ_LO_POS];
      mclk_ratio_o          <= ratio_fn(digital_config_q[`MCLK_FREQ_HI_POS:`MCLK_FREQ_LO_POS]);
      master_clock_pin_oe_o <= digital_config_q[`MCLK_OUT_ENABLE_POS];
      serial_format_o       <= digital_config_q[`SERIAL_FORMAT_SELECT_POS];
      serial_audio_oe_o     <= digital_config_q[`SERIAL_AUDIO_ENABLE_POS];
    end
  end

endmodule : audio_routing_dev

`default_nettype wire

// File: audio_routing_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "audio_routing_map.svh"

module audio_routing_ctrl #(
  parameter int LINK_HALF = `LINK_HALF_DEFAULT
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  audio_link_if.ctrl       link
);

  if (LINK_HALF < 1 || LINK_HALF > 255) begin : g_half_check
    $error("LINK_HALF out of range");
  end

  // --------------------------------------------------------------------------
  // Unused bits are forced to zero before a write is sent.
  // --------------------------------------------------------------------------
  function automatic logic [7:0] mask_fn(input logic [7:0] sub, input logic [7:0] val);
    logic [7:0] m;
    m = 8'hff;
    if (sub == `SUB_DAC_SOURCE_SELECT) begin
      m = `DAC_USED_MASK;
    end else if (sub == `SUB_ANALOG_OUTPUT_SELECT) begin
      m = `ANALOG_USED_MASK;
    end else if (sub == `SUB_DIGITAL_AUDIO_CONFIG) begin
      m = `DIGITAL_USED_MASK;
    end
    return val & m;
  endfunction : mask_fn

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  logic [15:0] cmd_q;
  logic        busy_q;
  logic        done_q;
  logic        done_set;
  logic        mapped;
  logic        access;

  assign mapped    = (paddr_i == `CTRL_CMD_OFFSET) || (paddr_i == `CTRL_STATUS_OFFSET);
  assign access    = psel_i && penable_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = access && !mapped;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      if (paddr_i == `CTRL_CMD_OFFSET) begin
        prdata_o <= {16'h0000, cmd_q};
      end else if (paddr_i == `CTRL_STATUS_OFFSET) begin
        prdata_o <= {30'h0000_0000, done_q, busy_q};
      end else begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cmd_q <= 16'h0000;
    end else if (access && pwrite_i && paddr_i == `CTRL_CMD_OFFSET && !busy_q) begin
      cmd_q <= {pwdata_i[15:8], mask_fn(pwdata_i[15:8], pwdata_i[7:0])};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1;
    end else if (access && pwrite_i && paddr_i == `CTRL_STATUS_OFFSET && pwdata_i[`CTRL_DONE_POS]) begin
      done_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Link clock divider and serialiser
  // --------------------------------------------------------------------------
  logic [7:0]  div_q;
  logic        tick;
  logic        fall;
  logic [15:0] sh_q;
  logic [4:0]  bits_q;
  audio_routing_pkg::ctrl_state_e state_q;

  assign tick     = (div_q == 8'(LINK_HALF - 1));
  assign fall     = tick && link.link_clk;
  assign done_set = fall && (state_q == audio_routing_pkg::CTRL_SEND) && (bits_q == 5'(`LINK_WORD_BITS));

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      div_q         <= 8'h00;
      link.link_clk <= 1'b0;
    end else if (tick) begin
      div_q         <= 8'h00;
      link.link_clk <= !link.link_clk;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      busy_q     <= 1'b0;
      state_q    <= audio_routing_pkg::CTRL_IDLE;
      sh_q       <= 16'h0000;
      bits_q     <= 5'h00;
      link.frame <= 1'b0;
      link.data  <= 1'b0;
    end else begin
      if (access && pwrite_i && paddr_i == `CTRL_CMD_OFFSET && !busy_q) begin
        busy_q <= 1'b1;
      end
      if (fall) begin
        unique case (state_q)
          audio_routing_pkg::CTRL_IDLE: begin
            if (busy_q) begin
              state_q    <= audio_routing_pkg::CTRL_SEND;
              link.frame <= 1'b1;
              link.data  <= cmd_q[15];
              sh_q       <= {cmd_q[14:0], 1'b0};
              bits_q     <= 5'h01;
            end
          end
          audio_routing_pkg::CTRL_SEND: begin
            if (bits_q == 5'(`LINK_WORD_BITS)) begin
              state_q    <= audio_routing_pkg::CTRL_IDLE;
              link.frame <= 1'b0;
              link.data  <= 1'b0;
              busy_q     <= 1'b0;
            end else begin
              link.data <= sh_q[15];
              sh_q      <= {sh_q[14:0], 1'b0};
              bits_q    <= bits_q + 5'h01;
            end
          end
        endcase
      end
    end
  end

endmodule : audio_routing_ctrl

`default_nettype wire

// File: audio_routing_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module audio_routing_monitor (
  input wire logic       link_clk,
  input wire logic       frame,
  input wire logic       rst_b_i,
  input wire logic [1:0] dac_src_o,
  input wire logic [1:0] dac_gain_o,
  input wire logic [3:0] dac_gain_db_o,
  input wire logic [1:0] analog_src_o,
  input wire logic [2:0] matrix_mode_o,
  input wire logic       dac_mute_o,
  input wire logic       automute_fallback_o,
  input wire logic [1:0] mclk_freq_o,
  input wire logic [9:0] mclk_ratio_o
);
  // --------------------------------------------------------------------------
  // Link framing and device output checks
  // --------------------------------------------------------------------------
  logic [4:0] frame_len_q;

  always_ff @(posedge link_clk) begin
    if (!rst_b_i || !frame) frame_len_q <= 5'h0;
    else frame_len_q <= frame_len_q + 5'h1;
  end

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_b_i);

  frame_len_a: assert property ($fell(frame) |-> frame_len_q == 5'd16)
    else $error("frame not sixteen link clocks long");
  gain_db_a: assert property ($stable(dac_gain_o) [*2] |-> dac_gain_db_o == 4'(dac_gain_o) * 4'd3)
    else $error("dac gain in dB does not match gain code");
  mute_src_a: assert property ($stable(analog_src_o) [*2] |-> dac_mute_o == (analog_src_o != 2'b00))
    else $error("dac mute does not follow analog source");
  avg_dac_a: assert property (matrix_mode_o == 3'b100 |-> analog_src_o == 2'b00)
    else $error("averaging used with analog input");
  mtx_code_a: assert property (matrix_mode_o <= 3'b100)
    else $error("reserved matrix code on output");
  src_code_a: assert property (analog_src_o != 2'b01)
    else $error("reserved analog source on output");
  ratio_map_a: assert property ($changed(mclk_freq_o) |-> ##[0:2] mclk_ratio_o ==
    (mclk_freq_o[1] ? (mclk_freq_o[0] ? 10'h300 : 10'h200) : (mclk_freq_o[0] ? 10'h180 : 10'h100)))
    else $error("master clock ratio wrong");
  fallback_a: assert property ((analog_src_o != 2'b00) [*2] |-> !automute_fallback_o)
    else $error("fallback active without dac source");
  reset_zero_a: assert property ($rose(rst_b_i) |-> dac_src_o == 2'b00 && matrix_mode_o == 3'b000 &&
    !dac_mute_o && mclk_ratio_o == 10'h100)
    else $error("outputs not at reset values");

  avg_c: cover property (matrix_mode_o == 3'b100);
  mute_c: cover property ($rose(dac_mute_o));
  frame_c: cover property ($fell(frame));
endmodule : audio_routing_monitor

`default_nettype wire

// File: tb_audio_output_routing_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "audio_routing_map.svh"

module tb_audio_output_routing_config;
  logic        mclk_i = 0, rst_b_i = 0, dev_rst_b = 0, fb_sel = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, mute, fbo, mclk_oe, fmt, ser_oe;
  logic [1:0]  dsrc, gain, asrc, freq;
  logic [3:0]  db;
  logic [2:0]  mtx;
  logic [9:0]  ratio;
  logic [7:0]  r13 = 0, r14 = 0, r15 = 0;
  logic [15:0] wsh;
  logic [31:0] rd, seed;
  logic        er;
  int          bad_count = 0, num_checks = 0, i;
  logic [29:0] expq[$];
  logic [7:0]  subq[$];
  wire  [29:0] seen = {dsrc, gain, db, asrc, mtx, mute, fbo, freq, ratio, mclk_oe, fmt, ser_oe};

  always #25 mclk_i = ~mclk_i;

  audio_link_if lk();
  audio_routing_ctrl #(.LINK_HALF(1)) audio_routing_ctrl_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(lk));
  audio_routing_dev audio_routing_dev_inst (.rst_b_i(dev_rst_b), .link(lk),
    .automute_fallback_select_i(fb_sel), .dac_src_o(dsrc), .dac_gain_o(gain), .dac_gain_db_o(db),
    .analog_src_o(asrc), .matrix_mode_o(mtx), .dac_mute_o(mute), .automute_fallback_o(fbo),
    .mclk_freq_o(freq), .mclk_ratio_o(ratio), .master_clock_pin_oe_o(mclk_oe),
    .serial_format_o(fmt), .serial_audio_oe_o(ser_oe));
  audio_routing_monitor audio_routing_monitor_inst (.link_clk(lk.link_clk), .frame(lk.frame),
    .rst_b_i(dev_rst_b), .dac_src_o(dsrc), .dac_gain_o(gain), .dac_gain_db_o(db),
    .analog_src_o(asrc), .matrix_mode_o(mtx), .dac_mute_o(mute), .automute_fallback_o(fbo),
    .mclk_freq_o(freq), .mclk_ratio_o(ratio));

  // --------------------------------------------------------------------------
  // Expected outputs from the three register images.
  // --------------------------------------------------------------------------
  function automatic logic [29:0] exp_f(input logic [7:0] a, b, c, input logic fb);
    logic [1:0] s;
    logic [2:0] m;
    logic [9:0] r;
    s = (b[1:0] == 2'b01) ? 2'b00 : b[1:0];
    m = (b[6:4] > 3'h4 || (b[6:4] == 3'h4 && s != 2'b00)) ? 3'h0 : b[6:4];
    r = c[4] ? (c[3] ? 10'h300 : 10'h200) : (c[3] ? 10'h180 : 10'h100);
    return {a[1:0], a[7], a[3], 4'({a[7], a[3]}) * 4'h3, s, m, s != 2'b00, fb & (s == 2'b00),
            c[4:3], r, c[2], c[1], c[0]};
  endfunction : exp_f

  task automatic check(input string nm, input logic [31:0] sv, ev);
    num_checks++;
    if (sv !== ev) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, ev, sv);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk_i);
    penable <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (pready === 1'b1) break;
    end
    if (n >= 50) begin
      bad_count++;
      results();
    end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic send(input logic [7:0] sub, dat);
    int n;
    logic [7:0] mk;
    apb(1, `CTRL_CMD_OFFSET, {16'h0, sub, dat});
    if (sub == 8'h13) r13 = dat;
    if (sub == 8'h14) r14 = dat;
    if (sub == 8'h15) r15 = dat;
    expq.push_back(exp_f(r13, r14, r15, fb_sel));
    subq.push_back(sub);
    n = 0;
    do begin
      apb(0, `CTRL_STATUS_OFFSET, 0);
      n++;
    end while (rd[`CTRL_BUSY_POS] !== 1'b0 && n < 400);
    if (rd[`CTRL_BUSY_POS] !== 1'b0) begin
      bad_count++;
      results();
    end
    check("status", rd, 32'h2);
    check("status error", 32'(er), 32'h0);
    mk = (sub == 8'h13) ? `DAC_USED_MASK : (sub == 8'h14) ? `ANALOG_USED_MASK :
         (sub == 8'h15) ? `DIGITAL_USED_MASK : 8'hff;
    apb(0, `CTRL_CMD_OFFSET, 0);
    check("cmd readback", rd, {16'h0, sub, dat & mk});
    apb(1, `CTRL_STATUS_OFFSET, 32'h2);
  endtask : send

  // --------------------------------------------------------------------------
  // Link watcher: word order on the wire and the device outputs after a frame.
  // --------------------------------------------------------------------------
  always @(posedge lk.link_clk) if (lk.frame) wsh <= {wsh[14:0], lk.data};

  initial begin
    wait (dev_rst_b === 1'b1);
    forever begin
      @(negedge lk.frame);
      if (subq.size() != 0) check("link subaddress", 32'(wsh[15:8]), 32'(subq.pop_front()));
      repeat (2) @(posedge lk.link_clk);
      #1;
      if (expq.size() != 0) check("outputs", 32'(seen), 32'(expq.pop_front()));
      else check("frame count", 32'h1, 32'h0);
    end
  end

  initial begin
    repeat (100000) @(posedge mclk_i);
    bad_count++;
    results();
  end

  initial begin
    seed = 32'hf71a2ec9;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1;
    repeat (20) @(posedge mclk_i);
    @(posedge lk.link_clk);
    dev_rst_b <= 1;
    @(posedge mclk_i);
    #1;
    check("reset outputs", 32'(seen), 32'(exp_f(8'h0, 8'h0, 8'h0, 1'b0)));
    $display("test reset done");
    for (i = 0; i < 16; i++) send(8'h13, {i[3], 3'b0, i[2], 1'b0, i[1:0]});
    fb_sel <= 1;
    for (i = 0; i < 32; i++) send(8'h14, {1'b0, i[4:2], 2'b00, i[1:0]});
    for (i = 0; i < 32; i++) send(8'h15, {3'b0, i[4:0]});
    $display("test directed codes done");
    for (i = 0; i < 24; i++) begin
      fb_sel <= 1'($random(seed));
      repeat (8) @(posedge mclk_i);
      send(8'h12 + 8'($unsigned($random(seed)) % 5), 8'($random(seed)));
    end
    $display("test random writes done");
    apb(1, 12'h008, 32'hffffffff);
    check("unmapped write error", 32'(er), 32'h1);
    apb(0, 12'h008, 0);
    check("unmapped read error", 32'(er), 32'h1);
    check("unmapped read data", rd, 32'h0);
    $display("test unmapped done");
    for (i = 0; i < 400 && expq.size() != 0; i++) @(posedge mclk_i);
    check("pending outputs", 32'(expq.size()), 32'h0);
    results();
  end
endmodule : tb_audio_output_routing_config

`default_nettype wire
